// [rtl/tct_pkg.sv]
package tct_pkg;

  // ---------------------------------------------------------------
  // Register map, byte addresses on the plain register port
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h0E;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h0F;
  localparam logic [7:0] ADDR_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_ENABLES = 8'h8C;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int BIT_OVERFLOW = 0;
  localparam int BIT_RUN = 0;
  localparam int BIT_SOURCE = 1;
  localparam int BIT_SYNC_BYPASS = 2;
  localparam int BIT_OSC_EN = 3;
  localparam int BIT_PRESCALE_LO = 4;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ---------------------------------------------------------------
  // Timing: the instruction clock is the system clock divided by four
  // ---------------------------------------------------------------
  localparam int INSN_DIVIDE = 4;
  localparam logic [1:0] INSN_LAST = 2'(INSN_DIVIDE - 1);

  // Prescale encodings
  localparam logic [1:0] PRESCALE_1 = 2'h0;
  localparam logic [1:0] PRESCALE_2 = 2'h1;
  localparam logic [1:0] PRESCALE_4 = 2'h2;
  localparam logic [1:0] PRESCALE_8 = 2'h3;

  // Control register layout, bit 0 last
  typedef struct packed {
    logic [1:0] unused;
    logic [1:0] prescale_select;
    logic crystal_osc_enable;
    logic sync_bypass;
    logic clock_source_select;
    logic counter_run;
  } tct_ctrl_t;

  // One register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tct_req_t;

  // Arming of counter mode: a falling edge must come first
  typedef enum logic [2:0] {
    ARM_IDLE = 3'b001,
    ARM_WAIT_FALL = 3'b010,
    ARM_COUNTING = 3'b100
  } tct_arm_t;

endpackage : tct_pkg

// [rtl/tct_prescaler.sv]
`timescale 1ns/1ns
module tct_prescaler
  import tct_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic tick_i,
  input wire logic [1:0] select_i,
  output logic pulse_o,
  output logic [2:0] count_o
);

  logic [2:0] count;
  logic [2:0] mask;
  wire logic [2:0] next_count = 3'(count + 3'h1);

  // -----------------------------------------------------------------
  // Divider stages
  // -----------------------------------------------------------------
  // Only the stages the ratio needs take part in the terminal match
  assign mask = (select_i == PRESCALE_8) ? 3'h7 :
                (select_i == PRESCALE_4) ? 3'h3 :
                (select_i == PRESCALE_2) ? 3'h1 : 3'h0;
  assign pulse_o = tick_i && ((count & mask) == mask);
  assign count_o = count;

  // Clear wins over a tick so a counter write restarts the division
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clear_i)
      count <= 3'h0;
    else if (tick_i)
      count <= next_count;
  end

endmodule : tct_prescaler

// [rtl/tct_timer.sv]
// Function
// - Sixteen-bit count held as high and low bytes, each read and written.
// - Count goes up from zero to all ones, then wraps to zero.
// - Wrap sets overflow flag bit 0; enable bit 0 gates the request.
// - Control bit 0 runs the counter when set, stops it when clear.
// - Source bit 0 picks instruction clock, 1 picks rising external edges.
// - Prescale field bits 5:4 divides by 1, 2, 4 or 8.
// - Oscillator enable forces both crystal pins to inputs reading zero.
// - Oscillator enable clear switches the oscillator inverter off.
// - Counter mode counts crystal input with oscillator on, else external pin.
// - Sync bit is ignored when the internal clock is selected.
// - After enabling counter mode a falling edge must precede counting.
// - Sync clear aligns after the prescaler; prescaler runs on raw edges.
// - Synchronised counter mode stops in sleep; prescaler keeps counting.
// - Sync set keeps counting through sleep; overflow interrupts and wakes.
// - Asynchronous counter mode offers no time base to capture or compare.
// - Special event trigger of either capture unit clears the counter.
// - Writing either counter byte clears the prescaler.
// - Power-on reset clears control to zero: stopped, prescale one.
// - A counter write beats a coinciding special event trigger.
// - Special event trigger never sets the overflow flag.
`timescale 1ns/1ns
module tct_timer
  import tct_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic EXT_COUNT_PIN_I,
  input wire logic CRYSTAL_IN_PIN_I,
  input wire logic [1:0] PORT_C_DIRECTION_I,
  input wire logic SLEEP_I,
  input wire logic [1:0] SPECIAL_EVENT_I,
  output logic CRYSTAL_OSC_EN_O,
  output logic [1:0] PORT_C_DIR_O,
  output logic [1:0] PIN_READ_O,
  output logic IRQ_O,
  output logic WAKE_O,
  output logic TIMEBASE_VALID_O,
  output logic [15:0] TIMEBASE_O
);

  import tct_pkg::*;

  // -----------------------------------------------------------------
  // Register port decode
  // -----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction : hit

  tct_req_t req;
  tct_ctrl_t ctrl;
  logic [15:0] count;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic [7:0] rdata;

  assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

  // Write strobes per register
  wire logic wr_low = req.wr && hit(req.addr, ADDR_COUNT_LOW);
  wire logic wr_high = req.wr && hit(req.addr, ADDR_COUNT_HIGH);
  wire logic wr_ctrl = req.wr && hit(req.addr, ADDR_CONTROL);
  wire logic wr_flags = req.wr && hit(req.addr, ADDR_FLAGS);
  wire logic wr_enables = req.wr && hit(req.addr, ADDR_ENABLES);
  wire logic wr_count = wr_low || wr_high;

  // -----------------------------------------------------------------
  // Pin input filters
  // -----------------------------------------------------------------
  // Three stages per pin; a level is accepted once stages two and three agree
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_s3;
  logic [1:0] pin_lvl;
  wire logic [1:0] pins_raw = {CRYSTAL_IN_PIN_I, EXT_COUNT_PIN_I};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_pin
      always_ff @(posedge SYS_CLK_I)
      begin
        if (SYS_RST_I)
        begin
          pin_s1[gi] <= 1'b0;
          pin_s2[gi] <= 1'b0;
          pin_s3[gi] <= 1'b0;
          pin_lvl[gi] <= 1'b0;
        end
        else
        begin
          pin_s1[gi] <= pins_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
          if (pin_s2[gi] == pin_s3[gi])
            pin_lvl[gi] <= pin_s2[gi];
        end
      end
    end
  endgenerate

  // -----------------------------------------------------------------
  // Source selection and edges
  // -----------------------------------------------------------------
  // Crystal input with the oscillator on, otherwise the external pin
  wire logic src_lvl = ctrl.crystal_osc_enable ? pin_lvl[1] : pin_lvl[0];
  logic src_prev;
  wire logic src_rise = src_lvl && !src_prev;
  wire logic src_fall = !src_lvl && src_prev;
  wire logic counter_mode = ctrl.clock_source_select;
  // The sync bit only matters with the external source selected
  wire logic async_mode = counter_mode && ctrl.sync_bypass;
  wire logic sync_mode = counter_mode && !ctrl.sync_bypass;

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      src_prev <= 1'b0;
    else
      src_prev <= src_lvl;
  end

  // -----------------------------------------------------------------
  // Instruction clock enable, system clock divided by four
  // -----------------------------------------------------------------
  logic [1:0] insn_div;
  wire logic insn_tick = (insn_div == INSN_LAST);

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      insn_div <= 2'h0;
    else
      insn_div <= 2'(insn_div + 2'h1);
  end

  // -----------------------------------------------------------------
  // Counter mode arming
  // -----------------------------------------------------------------
  tct_arm_t arm;
  tct_arm_t next_arm;
  wire logic arm_on = ctrl.counter_run && counter_mode;

  // A pin that idles high must first drop, so no spurious count on enable
  always_comb
  begin
    next_arm = arm;
    case (arm)
      ARM_IDLE: if (arm_on) next_arm = ARM_WAIT_FALL;
      ARM_WAIT_FALL: if (!arm_on) next_arm = ARM_IDLE;
        else if (src_fall) next_arm = ARM_COUNTING;
      ARM_COUNTING: if (!arm_on) next_arm = ARM_IDLE;
      default: next_arm = ARM_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      arm <= ARM_IDLE;
    else
      arm <= next_arm;
  end

  // -----------------------------------------------------------------
  // Prescaler
  // -----------------------------------------------------------------
  // External edges feed it even in sleep; the instruction clock stops there
  wire logic ext_tick = (arm == ARM_COUNTING) && src_rise;
  wire logic int_tick = !counter_mode && ctrl.counter_run && insn_tick && !SLEEP_I;
  wire logic pre_tick = counter_mode ? ext_tick : int_tick;
  logic pre_pulse;
  logic [2:0] pre_count;

  tct_prescaler u_prescaler (
    .clk_i(SYS_CLK_I),
    .rst_i(SYS_RST_I),
    .clear_i(wr_count),
    .tick_i(pre_tick),
    .select_i(ctrl.prescale_select),
    .pulse_o(pre_pulse),
    .count_o(pre_count)
  );

  // -----------------------------------------------------------------
  // Synchroniser after the prescaler
  // -----------------------------------------------------------------
  // Each prescaled edge in synchronised mode flips a toggle; two flops carry it, a third finds the change
  logic pre_toggle;
  logic sync1;
  logic sync2;
  logic sync3;
  wire logic sync_pulse = sync2 ^ sync3;

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      pre_toggle <= 1'b0;
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end
    else
    begin
      if (pre_pulse && sync_mode)
        pre_toggle <= !pre_toggle;
      sync1 <= pre_toggle;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // -----------------------------------------------------------------
  // Increment selection
  // -----------------------------------------------------------------
  // Synchronised mode loses its edges in sleep; the bypass path keeps running
  wire logic inc_timer = !counter_mode && pre_pulse;
  wire logic inc_async = async_mode && pre_pulse;
  wire logic inc_sync = sync_mode && sync_pulse && !SLEEP_I;
  wire logic inc = ctrl.counter_run && (inc_timer || inc_async || inc_sync);
  wire logic special_event = |SPECIAL_EVENT_I;
  wire logic wrap = inc && (count == COUNT_MAX) && !wr_count && !special_event;

  // -----------------------------------------------------------------
  // Counter bytes
  // -----------------------------------------------------------------
  // Software write wins, then the trigger clear, then counting
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      count <= COUNT_RESET;
    else if (wr_low)
      count[7:0] <= req.wdata;
    else if (wr_high)
      count[15:8] <= req.wdata;
    else if (special_event)
      count <= COUNT_RESET;
    else if (inc)
      count <= 16'(count + 16'h0001);
  end

  // -----------------------------------------------------------------
  // Control and interrupt bits
  // -----------------------------------------------------------------
  // Reset here stands for power-on or brown-out; other resets never reach it
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      ctrl <= tct_ctrl_t'(CONTROL_RESET);
    else if (wr_ctrl)
      ctrl <= tct_ctrl_t'({2'h0, req.wdata[5:0]});
  end

  // A wrap in the clearing cycle still leaves the flag set; trigger clears never set it
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      overflow_flag <= 1'b0;
      overflow_irq_enable <= 1'b0;
    end
    else
    begin
      if (wrap)
        overflow_flag <= 1'b1;
      else if (wr_flags)
        overflow_flag <= req.wdata[BIT_OVERFLOW];
      if (wr_enables)
        overflow_irq_enable <= req.wdata[BIT_OVERFLOW];
    end
  end

  assign IRQ_O = overflow_flag && overflow_irq_enable;

  // Wake only out of sleep, on the overflow itself
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      WAKE_O <= 1'b0;
    else
      WAKE_O <= wrap && SLEEP_I && overflow_irq_enable;
  end

  // -----------------------------------------------------------------
  // Read data, one cycle after the read strobe
  // -----------------------------------------------------------------
  // Reads are only glimpses of the count, so two byte reads can straddle a carry
  always_comb
  begin
    rdata = READ_ZERO;
    if (hit(req.addr, ADDR_COUNT_LOW))
      rdata = count[7:0];
    else if (hit(req.addr, ADDR_COUNT_HIGH))
      rdata = count[15:8];
    else if (hit(req.addr, ADDR_CONTROL))
      rdata = {2'h0, ctrl[5:0]};
    else if (hit(req.addr, ADDR_FLAGS))
      rdata = {7'h00, overflow_flag};
    else if (hit(req.addr, ADDR_ENABLES))
      rdata = {7'h00, overflow_irq_enable};
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      RDATA_O <= READ_ZERO;
    else if (req.rd)
      RDATA_O <= rdata;
    else
      RDATA_O <= READ_ZERO;
  end

  // -----------------------------------------------------------------
  // Pins and time base
  // -----------------------------------------------------------------
  // Oscillator enable drives the inverter enable straight from the control bit
  assign CRYSTAL_OSC_EN_O = ctrl.crystal_osc_enable;
  assign PORT_C_DIR_O = ctrl.crystal_osc_enable ? 2'h3 : PORT_C_DIRECTION_I;

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      PIN_READ_O <= 2'h0;
      TIMEBASE_VALID_O <= 1'b0;
      TIMEBASE_O <= COUNT_RESET;
    end
    else
    begin
      PIN_READ_O <= ctrl.crystal_osc_enable ? 2'h0 : pin_lvl;
      TIMEBASE_VALID_O <= !async_mode;
      TIMEBASE_O <= count;
    end
  end

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_prescaled_sync;
    pre_pulse && sync_mode;
  endsequence

  // Toggle flop, two carrying flops, then the change shows on the third edge
  sequence s_edge_through_sync;
    !sync_pulse ##1 !sync_pulse ##1 !sync_pulse ##1 sync_pulse;
  endsequence

  property p_wrap_flag;
    wrap |=> overflow_flag && (count == COUNT_RESET);
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("wrap lost flag");

  property p_increment;
    inc && !wr_count && !special_event |=> count == 16'($past(count) + 16'h0001);
  endproperty
  a_increment: assert property (p_increment) else $error("bad increment");

  property p_stopped;
    !ctrl.counter_run && !wr_count && !special_event |=> $stable(count);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped counter moved");

  property p_prescale_clear;
    wr_count |=> pre_count == 3'h0;
  endproperty
  a_prescale_clear: assert property (p_prescale_clear) else $error("prescaler kept");

  property p_write_wins;
    wr_low && special_event |=> count[7:0] == $past(WDATA_I);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("trigger beat write");

  property p_trigger_no_flag;
    special_event && !wr_flags |=> overflow_flag == $past(overflow_flag);
  endproperty
  a_trigger_no_flag: assert property (p_trigger_no_flag) else $error("trigger set flag");

  property p_trigger_clear;
    special_event && !wr_count |=> count == COUNT_RESET;
  endproperty
  a_trigger_clear: assert property (p_trigger_clear) else $error("trigger kept count");

  property p_osc_pins;
    ctrl.crystal_osc_enable |-> PORT_C_DIR_O == 2'h3 ##1 PIN_READ_O == 2'h0;
  endproperty
  a_osc_pins: assert property (p_osc_pins) else $error("crystal pins not forced");

  property p_arm_needs_fall;
    arm == ARM_WAIT_FALL && !src_fall |=> arm != ARM_COUNTING;
  endproperty
  a_arm_needs_fall: assert property (p_arm_needs_fall) else $error("armed without fall");

  property p_sleep_sync;
    sync_mode && SLEEP_I |-> !inc;
  endproperty
  a_sleep_sync: assert property (p_sleep_sync) else $error("sync count in sleep");

  property p_sync_delay;
    s_prescaled_sync |-> s_edge_through_sync;
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync edge timing");

  property p_ctrl_reset;
    // Own disable term, as the default one would mute this check entirely
    @(posedge SYS_CLK_I) disable iff (1'b0) SYS_RST_I |=> ctrl == tct_ctrl_t'(CONTROL_RESET);
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not cleared");

endmodule : tct_timer

// [testbench/tb_top.sv]
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("[FAIL] t=%0t got %h expected %h", $time, (got), (exp)); \
    end \
  end

module tb_top;
  import tct_pkg::*;
  logic clk, rst, wr, rd, sleep, go, to_x, ext, xtal, osc_en, irq, wake, tb_valid;
  logic [7:0] addr, wdata, rdata, half;
  logic [1:0] dir_in, sev, dir_out, pin_rd;
  logic [15:0] tb_val;
  int fails, samples_checked, wakes;

  // ---------------------------------------------------------------
  // Design, far side and clock
  // ---------------------------------------------------------------
  tct_timer tct_timer_i (.SYS_CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .EXT_COUNT_PIN_I(ext), .CRYSTAL_IN_PIN_I(xtal),
    .PORT_C_DIRECTION_I(dir_in), .SLEEP_I(sleep), .SPECIAL_EVENT_I(sev),
    .CRYSTAL_OSC_EN_O(osc_en), .PORT_C_DIR_O(dir_out), .PIN_READ_O(pin_rd), .IRQ_O(irq),
    .WAKE_O(wake), .TIMEBASE_VALID_O(tb_valid), .TIMEBASE_O(tb_val));
  tct_pulse_src tct_pulse_src_i (.clk_i(clk), .go_i(go), .half_i(half), .to_crystal_i(to_x),
    .ext_pin_o(ext), .crystal_pin_o(xtal));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Wake pulses last one cycle, so they are counted as they pass
  always @(posedge clk)
    if (wake === 1'b1)
      wakes++;

  // ---------------------------------------------------------------
  // Register port tasks
  // ---------------------------------------------------------------
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : bus_rd

  task automatic set_count(input logic [15:0] v);
    bus_wr(ADDR_COUNT_LOW, v[7:0]);
    bus_wr(ADDR_COUNT_HIGH, v[15:8]);
  endtask : set_count

  task automatic get_count(output logic [15:0] v);
    bus_rd(ADDR_COUNT_LOW, v[7:0]);
    bus_rd(ADDR_COUNT_HIGH, v[15:8]);
  endtask : get_count

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] v;
    bus_rd(ADDR_CONTROL, v);
    `CHK(v, CONTROL_RESET)
    bus_rd(ADDR_FLAGS, v);
    `CHK(v, 8'h00)
    bus_rd(8'h20, v);
    `CHK(v, READ_ZERO)
    `CHK(irq, 1'b0)
    $display("test reset done");
  endtask : t_reset

  task automatic t_bytes;
    logic [15:0] c;
    logic [7:0] v;
    set_count(16'hA55A);
    get_count(c);
    `CHK(c, 16'hA55A)
    bus_wr(ADDR_CONTROL, 8'hF4);
    bus_rd(ADDR_CONTROL, v);
    `CHK(v, 8'h34)
    bus_wr(ADDR_CONTROL, 8'h00);
    $display("test bytes done");
  endtask : t_bytes

  // Count writes clear the prescaler, so each run starts from a known phase
  task automatic t_timer;
    logic [7:0] ctl [5] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h05};
    int ex [5] = '{32, 16, 8, 4, 32};
    logic [15:0] c;
    for (int i = 0; i < 5; i++)
    begin
      set_count(16'h0000);
      bus_wr(ADDR_CONTROL, ctl[i]);
      repeat (128) @(posedge clk);
      bus_wr(ADDR_CONTROL, 8'h00);
      get_count(c);
      `CHK(c >= 16'(ex[i] - 1) && c <= 16'(ex[i] + 1), 1'b1)
    end
    $display("test timer done");
  endtask : t_timer

  // Frame of five rises starting low: the first rise comes before any fall
  task automatic t_counter(input logic [7:0] ctl, input logic xs, input logic slp,
    input logic [7:0] h, input logic [15:0] start, input logic [15:0] exp);
    logic [15:0] c;
    set_count(start);
    // Inputs move on the rising edge, never in mid-cycle
    @(posedge clk);
    to_x <= xs;
    sleep <= slp;
    half <= h;
    bus_wr(ADDR_CONTROL, ctl);
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    #1;
    `CHK(tb_valid, ~(ctl[1] & ctl[2]))
    `CHK(osc_en, ctl[3])
    `CHK(dir_out, ctl[3] ? 2'b11 : dir_in)
    if (ctl[3])
      `CHK(pin_rd, 2'b00)
    repeat (10 * h + 20) @(posedge clk);
    sleep <= 1'b0;
    bus_wr(ADDR_CONTROL, 8'h00);
    get_count(c);
    `CHK(c, exp)
    `CHK(tb_val, exp)
    $display("test counter %h done", ctl);
  endtask : t_counter

  task automatic t_irq;
    logic [7:0] v;
    `CHK(irq, 1'b1)
    bus_wr(ADDR_ENABLES, 8'h00);
    `CHK(irq, 1'b0)
    bus_wr(ADDR_FLAGS, 8'h00);
    bus_rd(ADDR_FLAGS, v);
    `CHK(v, 8'h00)
    $display("test interrupt done");
  endtask : t_irq

  task automatic t_trigger;
    logic [15:0] c;
    logic [7:0] v;
    for (int i = 0; i < 2; i++)
    begin
      // Start at the top value so a clear that looked like a wrap would raise the flag
      set_count(COUNT_MAX);
      @(posedge clk);
      sev <= 2'b01 << i;
      @(posedge clk);
      sev <= 2'b00;
      get_count(c);
      `CHK(c, COUNT_RESET)
      bus_rd(ADDR_FLAGS, v);
      `CHK(v, 8'h00)
    end
    set_count(16'h0012);
    @(posedge clk);
    addr <= ADDR_COUNT_LOW;
    wdata <= 8'h77;
    wr <= 1'b1;
    sev <= 2'b10;
    @(posedge clk);
    wr <= 1'b0;
    sev <= 2'b00;
    get_count(c);
    `CHK(c, 16'h0077)
    $display("test trigger done");
  endtask : t_trigger

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    int w0;
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    sleep = 1'b0;
    sev = 2'b00;
    go = 1'b0;
    to_x = 1'b0;
    half = 8'h08;
    dir_in = 2'b01;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_bytes();
    t_timer();
    t_counter(8'h03, 1'b0, 1'b0, 8'h08, 16'h0000, 16'h0004);
    t_counter(8'h07, 1'b0, 1'b0, 8'h08, 16'h0000, 16'h0004);
    t_counter(8'h0B, 1'b1, 1'b0, 8'h14, 16'h0000, 16'h0004);
    t_counter(8'h23, 1'b0, 1'b0, 8'h08, 16'h0000, 16'h0001);
    t_counter(8'h03, 1'b0, 1'b1, 8'h08, 16'h0000, 16'h0000);
    bus_wr(ADDR_ENABLES, 8'h01);
    w0 = wakes;
    t_counter(8'h07, 1'b0, 1'b1, 8'h08, 16'hFFFE, 16'h0002);
    `CHK(wakes == w0 + 1, 1'b1)
    t_irq();
    t_trigger();
    test_done();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    test_done();
  end
endmodule : tb_top

// [testbench/tct_pulse_src.sv]
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Far side: external count clock or low-power crystal
// ---------------------------------------------------------------
module tct_pulse_src (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [7:0] half_i,
  input wire logic to_crystal_i,
  output logic ext_pin_o,
  output logic crystal_pin_o
);
  logic level;

  // Five full periods per frame; the source stands low between frames
  initial
  begin
    level = 1'b0;
    forever
    begin
      @(posedge clk_i);
      if (go_i)
      begin
        repeat (5)
        begin
          repeat (half_i) @(posedge clk_i);
          level <= 1'b1;
          repeat (half_i) @(posedge clk_i);
          level <= 1'b0;
        end
      end
    end
  end

  // The pin not in use sits at its pull-down level
  assign ext_pin_o = to_crystal_i ? 1'b0 : level;
  assign crystal_pin_o = to_crystal_i ? level : 1'b0;
endmodule : tct_pulse_src
